//--- pid_pkg.sv
// Shared constants and types for the prioritized interrupt dispatcher
package pid_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TIMER_RES_NS  = 100000;
  localparam int unsigned TICK_CYCLES   = TIMER_RES_NS / CLK_PERIOD_NS;

  localparam int unsigned NUM_SRC   = 10;
  localparam int unsigned SRC_W     = 4;
  localparam int unsigned NUM_INPUT = 4;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned TMR_W     = 16;

  localparam logic [SRC_W-1:0] SRC_IN0    = 4'h0;
  localparam logic [SRC_W-1:0] SRC_PCNT1  = 4'h4;
  localparam logic [SRC_W-1:0] SRC_PCNT2  = 4'h5;
  localparam logic [SRC_W-1:0] SRC_TIM0   = 4'h6;
  localparam logic [SRC_W-1:0] SRC_TIM1   = 4'h7;
  localparam logic [SRC_W-1:0] SRC_TIM2   = 4'h8;
  localparam logic [SRC_W-1:0] SRC_SERIAL = 4'h9;

  localparam int unsigned FAST_TIMERS     = 16;
  localparam logic [4:0]  FAST_CNT_RESET  = 5'h10;
  localparam logic [3:0]  MASK_RESET      = 4'hf;

  typedef enum logic [1:0] {
    PID_LVL_NONE = 2'b00,
    PID_LVL_LOW  = 2'b01,
    PID_LVL_MID  = 2'b10,
    PID_LVL_TOP  = 2'b11
  } pid_level_t;

  typedef enum logic {
    PID_CMP_TARGET = 1'b0,
    PID_CMP_RANGE  = 1'b1
  } pid_cmp_mode_t;

endpackage : pid_pkg

//--- pid_counter.sv
// Two-phase / absolute counter with target or range comparison
`timescale 1ns/1ns
`default_nettype none
module pid_counter (
  input  wire logic                      sys_clk,       // System clock
  input  wire logic                      rst,           // Synchronous reset
  input  wire logic                      phase_a,       // Phase A pulse input
  input  wire logic                      phase_b,       // Phase B pulse input
  input  wire logic                      zero,          // Count clear
  input  wire logic                      abs_mode,      // Track absolute code
  input  wire logic [pid_pkg::CNT_W-1:0] abs_code,      // Absolute encoder code
  input  wire pid_pkg::pid_cmp_mode_t    cmp_mode,      // Target or range
  input  wire logic [pid_pkg::CNT_W-1:0] cmp_lo,        // Target / range low
  input  wire logic [pid_pkg::CNT_W-1:0] cmp_hi,        // Range high
  output logic      [pid_pkg::CNT_W-1:0] present_count, // Current count
  output logic                           match,         // Comparison true
  output logic                           hit            // Request; pulse in target mode, held while inside in range mode
);

  logic                      prev_a;
  logic                      prev_b;
  logic [pid_pkg::CNT_W-1:0] next_count;
  logic                      next_match;
  logic                      next_hit;
  logic                      cmp_now;

  always_comb
  begin
    next_count = present_count;
    if (zero)
      next_count = '0;
    else if (abs_mode)
      next_count = abs_code;
    else if ((phase_a ^ prev_a) || (phase_b ^ prev_b))
    begin
      // Quadrature x4 decode: direction from old A versus new B
      if (prev_a ^ phase_b)
        next_count = present_count - 1'b1;
      else
        next_count = present_count + 1'b1;
    end
    if (cmp_mode == pid_pkg::PID_CMP_TARGET)
      cmp_now = (next_count == cmp_lo);
    else
      cmp_now = (next_count >= cmp_lo) && (next_count <= cmp_hi);
    next_match = cmp_now;
    // Target fires once on arrival; range requests for as long as it is inside
    next_hit   = (cmp_mode == pid_pkg::PID_CMP_RANGE) ? cmp_now : (cmp_now && !match);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prev_a        <= 1'b0;
      prev_b        <= 1'b0;
      present_count <= '0;
      match         <= 1'b0;
      hit           <= 1'b0;
    end
    else
    begin
      prev_a        <= phase_a;
      prev_b        <= phase_b;
      present_count <= next_count;
      match         <= next_match;
      hit           <= next_hit;
    end
  end

endmodule // pid_counter
`default_nettype wire

//--- pid_dispatcher.sv
// Prioritized interrupt dispatcher: sources, pending latches, preemption stack
`timescale 1ns/1ns
`default_nettype none
module pid_dispatcher #(
  parameter int unsigned TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
  input  wire logic                      sys_clk,        // 250 MHz clock
  input  wire logic                      rst,            // Synchronous reset
  input  wire logic [3:0]                ext_in,         // External input bits
  input  wire logic                      mask_wr,        // Load input masks
  input  wire logic [3:0]                mask_data,      // 1 = masked
  input  wire logic [3:0]                pend_clr,       // Drop latched input requests
  input  wire logic [3:0]                refresh_en,     // Refresh inputs before handler
  input  wire logic [1:0]                tmr_en,         // Interval timer 0/1 enable
  input  wire logic [pid_pkg::TMR_W-1:0] tmr0_period,    // Timer 0 period, 0.1 ms units
  input  wire logic [pid_pkg::TMR_W-1:0] tmr1_period,    // Timer 1 period, 0.1 ms units
  input  wire logic                      fast_cfg_wr,    // Load fast timer count
  input  wire logic [4:0]                fast_cfg,       // Fast timers using interrupts
  input  wire logic [2:0]                ctr0_in,        // Counter 0: A, B, zero
  input  wire logic [1:0]                port_a,         // Board ports 1/2 phase A
  input  wire logic [1:0]                port_b,         // Board ports 1/2 phase B
  input  wire logic [1:0]                port_abs,       // Port runs absolute encoder
  input  wire logic [pid_pkg::CNT_W-1:0] abs_code1,      // Port 1 encoder code
  input  wire logic [pid_pkg::CNT_W-1:0] abs_code2,      // Port 2 encoder code
  input  wire logic [2:0]                cmp_range,      // Ctr0/1/2 range mode
  input  wire logic [pid_pkg::CNT_W-1:0] cmp_lo,         // Shared compare low
  input  wire logic [pid_pkg::CNT_W-1:0] cmp_hi,         // Shared compare high
  input  wire logic [1:0]                hsb_in,         // Counter board A/B
  input  wire logic [pid_pkg::CNT_W-1:0] hsb_lo,         // Counter board low
  input  wire logic [pid_pkg::CNT_W-1:0] hsb_hi,         // Counter board high
  input  wire logic                      hsb_range,      // Counter board range mode
  input  wire logic                      serial_req,     // Serial board message pulse
  input  wire logic                      handler_done,   // Handler end marker pulse
  output logic                           handler_start,  // Begin marker pulse
  output logic      [pid_pkg::SRC_W-1:0] handler_id,     // Handler of start/resume
  output logic                           handler_resume, // Suspended handler resumes
  output logic                           refresh_req,    // Refresh inputs for start
  output logic      [1:0]                run_level,      // Running level
  output logic      [3:0]                mask_status,    // Input masks
  output logic      [pid_pkg::NUM_SRC-1:0] pend_status,  // Pending requests
  output logic      [pid_pkg::FAST_TIMERS-1:0] fast_irq_sel, // Fast timers on interrupts
  output logic                           hsb_pattern     // Counter board compare output
);

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

  // Source index order is also the service order, so lowest index wins
  function automatic pid_pkg::pid_level_t src_level(input logic [pid_pkg::SRC_W-1:0] s);
    if (s <= pid_pkg::SRC_PCNT2)
      src_level = pid_pkg::PID_LVL_TOP;
    else if (s <= pid_pkg::SRC_TIM2)
      src_level = pid_pkg::PID_LVL_MID;
    else
      src_level = pid_pkg::PID_LVL_LOW;
  endfunction

  function automatic pid_pkg::pid_level_t top_active(input logic [3:1] act);
    if (act[3])
      top_active = pid_pkg::PID_LVL_TOP;
    else if (act[2])
      top_active = pid_pkg::PID_LVL_MID;
    else if (act[1])
      top_active = pid_pkg::PID_LVL_LOW;
    else
      top_active = pid_pkg::PID_LVL_NONE;
  endfunction

  // Counters
  logic [2:0] cnt_hit;
  logic       hsb_match;

  pid_counter u_ctr0 (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .phase_a       (ctr0_in[0]),
    .phase_b       (ctr0_in[1]),
    .zero          (ctr0_in[2]),
    .abs_mode      (1'b0),
    .abs_code      ('0),
    .cmp_mode      (pid_pkg::pid_cmp_mode_t'(cmp_range[0])),
    .cmp_lo        (cmp_lo),
    .cmp_hi        (cmp_hi),
    .present_count (),
    .match         (),
    .hit           (cnt_hit[0])
  );

  pid_counter u_ctr1 (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .phase_a       (port_a[0]),
    .phase_b       (port_b[0]),
    .zero          (1'b0),
    .abs_mode      (port_abs[0]),
    .abs_code      (abs_code1),
    .cmp_mode      (pid_pkg::pid_cmp_mode_t'(cmp_range[1])),
    .cmp_lo        (cmp_lo),
    .cmp_hi        (cmp_hi),
    .present_count (),
    .match         (),
    .hit           (cnt_hit[1])
  );

  pid_counter u_ctr2 (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .phase_a       (port_a[1]),
    .phase_b       (port_b[1]),
    .zero          (1'b0),
    .abs_mode      (port_abs[1]),
    .abs_code      (abs_code2),
    .cmp_mode      (pid_pkg::pid_cmp_mode_t'(cmp_range[2])),
    .cmp_lo        (cmp_lo),
    .cmp_hi        (cmp_hi),
    .present_count (),
    .match         (),
    .hit           (cnt_hit[2])
  );

  // Counter-board channel: its comparison drives a pin, never a request
  pid_counter u_hsb (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .phase_a       (hsb_in[0]),
    .phase_b       (hsb_in[1]),
    .zero          (1'b0),
    .abs_mode      (1'b0),
    .abs_code      ('0),
    .cmp_mode      (pid_pkg::pid_cmp_mode_t'(hsb_range)),
    .cmp_lo        (hsb_lo),
    .cmp_hi        (hsb_hi),
    .present_count (),
    .match         (hsb_match),
    .hit           ()
  );

  // Time base and interval timers
  logic [TICK_W-1:0]         tick_cnt;
  logic [TICK_W-1:0]         next_tick_cnt;
  logic                      tick;
  logic [pid_pkg::TMR_W-1:0] tmr_cnt [2];
  logic [pid_pkg::TMR_W-1:0] next_tmr_cnt [2];
  logic [1:0]                tmr_hit;
  logic [pid_pkg::TMR_W-1:0] tmr_period [2];

  assign tmr_period[0] = tmr0_period;
  assign tmr_period[1] = tmr1_period;
  assign tick          = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  always_comb
  begin
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      next_tmr_cnt[i] = tmr_cnt[i];
      tmr_hit[i]      = 1'b0;
      if (!tmr_en[i] || tmr_period[i] == '0)
        next_tmr_cnt[i] = '0;
      else if (tick)
      begin
        if (tmr_cnt[i] + 1'b1 >= tmr_period[i])
        begin
          next_tmr_cnt[i] = '0;
          tmr_hit[i]      = 1'b1;
        end
        else
          next_tmr_cnt[i] = tmr_cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tick_cnt   <= '0;
      tmr_cnt[0] <= '0;
      tmr_cnt[1] <= '0;
    end
    else
    begin
      tick_cnt   <= next_tick_cnt;
      tmr_cnt[0] <= next_tmr_cnt[0];
      tmr_cnt[1] <= next_tmr_cnt[1];
    end
  end

  // Pending latches, masks and dispatch stack
  logic [3:0]                  ext_prev;
  logic [3:0]                  next_mask;
  logic [pid_pkg::NUM_SRC-1:0] set_req;
  logic [pid_pkg::NUM_SRC-1:0] clr_req;
  logic [pid_pkg::NUM_SRC-1:0] eligible;
  logic [pid_pkg::NUM_SRC-1:0] next_pend;
  logic [3:1]                  active;
  logic [3:1]                  next_active;
  logic [pid_pkg::SRC_W-1:0]   act_id [4];
  logic [pid_pkg::SRC_W-1:0]   next_act_id [4];
  logic [4:0]                  fast_cnt;
  logic [4:0]                  next_fast_cnt;
  logic                        next_start;
  logic                        next_resume;
  logic                        next_refresh;
  logic [pid_pkg::SRC_W-1:0]   next_id;
  logic [pid_pkg::FAST_TIMERS-1:0] next_fast_sel;
  pid_pkg::pid_level_t         cur_lvl;
  pid_pkg::pid_level_t         cand_lvl;
  pid_pkg::pid_level_t         rem_lvl;
  logic [pid_pkg::SRC_W-1:0]   cand;
  logic                        cand_ok;

  always_comb
  begin
    set_req = '0;
    set_req[3:0] = ext_in & ~ext_prev;
    set_req[pid_pkg::SRC_PCNT1]  = cnt_hit[1];
    set_req[pid_pkg::SRC_PCNT2]  = cnt_hit[2];
    set_req[pid_pkg::SRC_TIM0]   = tmr_hit[0];
    set_req[pid_pkg::SRC_TIM1]   = tmr_hit[1];
    set_req[pid_pkg::SRC_TIM2]   = cnt_hit[0];
    set_req[pid_pkg::SRC_SERIAL] = serial_req;
    next_mask = mask_wr ? mask_data : mask_status;
    eligible  = pend_status;
    eligible[3:0] = pend_status[3:0] & ~mask_status;
    cand    = '0;
    cand_ok = 1'b0;
    for (int i = pid_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        cand    = pid_pkg::SRC_W'(i);
        cand_ok = 1'b1;
      end
    end
    cur_lvl   = top_active(active);
    cand_lvl  = src_level(cand);
    next_active  = active;
    next_act_id  = act_id;
    next_start   = 1'b0;
    next_resume  = 1'b0;
    next_refresh = 1'b0;
    next_id      = handler_id;
    clr_req      = '0;
    clr_req[3:0] = pend_clr;
    rem_lvl      = pid_pkg::PID_LVL_NONE;
    if (handler_done && cur_lvl != pid_pkg::PID_LVL_NONE)
    begin
      // Completion is handled alone; the next dispatch waits one cycle
      next_active[cur_lvl] = 1'b0;
      rem_lvl = top_active(next_active);
      if (rem_lvl != pid_pkg::PID_LVL_NONE)
      begin
        next_resume = 1'b1;
        next_id     = act_id[rem_lvl];
      end
    end
    else if (cand_ok && cand_lvl > cur_lvl)
    begin
      next_active[cand_lvl] = 1'b1;
      next_act_id[cand_lvl] = cand;
      next_start   = 1'b1;
      next_id      = cand;
      next_refresh = (cand < pid_pkg::SRC_PCNT1) && refresh_en[cand[1:0]];
      clr_req[cand] = 1'b1;
    end
    // A new request in the cycle it is cleared stays pending
    next_pend = (pend_status & ~clr_req) | set_req;
    next_fast_cnt = fast_cfg_wr ? fast_cfg : fast_cnt;
    for (int i = 0; i < pid_pkg::FAST_TIMERS; i++)
      next_fast_sel[i] = (5'(i) < next_fast_cnt);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ext_prev       <= '0;
      mask_status    <= pid_pkg::MASK_RESET;
      pend_status    <= '0;
      active         <= '0;
      act_id[0]      <= '0;
      act_id[1]      <= '0;
      act_id[2]      <= '0;
      act_id[3]      <= '0;
      handler_start  <= 1'b0;
      handler_resume <= 1'b0;
      refresh_req    <= 1'b0;
      handler_id     <= '0;
      run_level      <= '0;
      fast_cnt       <= pid_pkg::FAST_CNT_RESET;
      fast_irq_sel   <= '1;
      hsb_pattern    <= 1'b0;
    end
    else
    begin
      ext_prev       <= ext_in;
      mask_status    <= next_mask;
      pend_status    <= next_pend;
      active         <= next_active;
      act_id         <= next_act_id;
      handler_start  <= next_start;
      handler_resume <= next_resume;
      refresh_req    <= next_refresh;
      handler_id     <= next_id;
      run_level      <= top_active(next_active);
      fast_cnt       <= next_fast_cnt;
      fast_irq_sel   <= next_fast_sel;
      hsb_pattern    <= hsb_match;
    end
  end

endmodule // pid_dispatcher
`default_nettype wire

//--- pid_dispatcher_props.sv
// Concurrent checks on the ports of the interrupt dispatcher
`timescale 1ns/1ns
`default_nettype none
module pid_dispatcher_props #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic                      sys_clk,        // Clock
  input wire logic                      rst,            // Reset
  input wire logic [3:0]                ext_in,         // External inputs
  input wire logic                      fast_cfg_wr,    // Fast count load
  input wire logic [4:0]                fast_cfg,       // Fast count
  input wire logic                      handler_done,   // Handler end
  input wire logic                      handler_start,  // Handler begin
  input wire logic [pid_pkg::SRC_W-1:0] handler_id,     // Handler source
  input wire logic                      handler_resume, // Resume pulse
  input wire logic                      refresh_req,    // Refresh pulse
  input wire logic [1:0]                run_level,      // Running level
  input wire logic [3:0]                mask_status,    // Masks
  input wire logic [9:0]                pend_status,    // Pending
  input wire logic [15:0]               fast_irq_sel    // Fast selection
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reset_state: assert property ($past(rst) |-> mask_status == 4'hf && run_level == 2'h0
    && fast_irq_sel == 16'hffff) else $error("state after reset wrong");
  a_start_level_up: assert property (handler_start |-> run_level > $past(run_level))
    else $error("start without higher level");
  a_top_level: assert property (handler_start && handler_id <= 4'h5 |-> run_level == 2'h3)
    else $error("input or board counter not top level");
  a_mid_level: assert property (handler_start && handler_id inside {[4'h6:4'h8]} |-> run_level == 2'h2)
    else $error("timer not middle level");
  a_low_level: assert property (handler_start && handler_id == 4'h9 |-> run_level == 2'h1)
    else $error("serial not bottom level");
  a_input_dispatch: assert property ($rose(ext_in[0]) && !mask_status[0] && run_level == 2'h0
    && pend_status == 10'h0 && !handler_done |-> ##2 handler_start && handler_id == 4'h0)
    else $error("input 0 edge not dispatched");
  a_equal_waits: assert property (run_level == 2'h3 && !handler_done |=> !handler_start)
    else $error("start while top level runs");
  a_done_drops: assert property (handler_done && run_level != 2'h0 |=> run_level < $past(run_level))
    else $error("level kept after done");
  a_resume_lower: assert property (handler_resume |-> run_level < $past(run_level) && !handler_start)
    else $error("resume level wrong");
  a_refresh_pair: assert property (refresh_req |-> handler_start && handler_id < 4'h4)
    else $error("refresh without input start");
  a_fast_select: assert property (fast_cfg_wr && fast_cfg <= 5'h10
    |=> fast_irq_sel == 16'((32'h1 << $past(fast_cfg)) - 32'h1)) else $error("fast selection wrong");
  a_masked_held: assert property (mask_status[2] && pend_status[2]
    |=> !(handler_start && handler_id == 4'h2)) else $error("masked input dispatched");

  c_resume: cover property (handler_resume);
  c_counter: cover property (handler_start && handler_id == 4'h4);
  c_timer: cover property (handler_start && run_level == 2'h2);
endmodule // pid_dispatcher_props

bind pid_dispatcher pid_dispatcher_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst(rst), .ext_in(ext_in), .fast_cfg_wr(fast_cfg_wr), .fast_cfg(fast_cfg),
  .handler_done(handler_done), .handler_start(handler_start), .handler_id(handler_id),
  .handler_resume(handler_resume), .refresh_req(refresh_req), .run_level(run_level),
  .mask_status(mask_status), .pend_status(pend_status), .fast_irq_sel(fast_irq_sel));
`default_nettype wire

//--- pid_src_model.sv
// Model of the request sources: input pins, pulse board ports and serial board
`timescale 1ns/1ns
`default_nettype none
module pid_src_model (
  input  wire logic       sys_clk,    // Clock
  output logic      [3:0] ext_in,     // External input bits
  output logic            serial_req, // Message received pulse
  output logic      [2:0] ctr0_in,    // Counter 0 A, B, zero
  output logic      [1:0] port_a,     // Board phase A
  output logic      [1:0] port_b      // Board phase B
);
  initial
  begin
    ext_in = 4'h0;
    serial_req = 1'b0;
    ctr0_in = 3'h0;
    port_a = 2'h0;
    port_b = 2'h0;
  end

  // Levels held a few cycles, as a real contact would be
  task automatic raise_inputs(input logic [3:0] bits);
    @(posedge sys_clk);
    ext_in <= bits;
    repeat (3) @(posedge sys_clk);
    ext_in <= 4'h0;
  endtask

  task automatic message_received();
    @(posedge sys_clk);
    serial_req <= 1'b1;
    @(posedge sys_clk);
    serial_req <= 1'b0;
  endtask

  // Forward quadrature on port 1; four cycles a phase, far faster than a real encoder
  task automatic quad_steps(input logic [3:0] n);
    logic [1:0] ph;
    ph = 2'h0;
    repeat (n)
    begin
      ph = ph + 2'h1;
      repeat (4) @(posedge sys_clk);
      port_a[0] <= ph[1] ^ ph[0];
      port_b[0] <= ph[1];
    end
  endtask

  // Same forward sequence on the built-in counter's A/B pins
  task automatic ctr0_steps(input logic [3:0] n);
    logic [1:0] ph;
    ph = 2'h0;
    repeat (n)
    begin
      ph = ph + 2'h1;
      repeat (4) @(posedge sys_clk);
      ctr0_in[0] <= ph[1] ^ ph[0];
      ctr0_in[1] <= ph[1];
    end
  endtask
endmodule // pid_src_model
`default_nettype wire

//--- pid_dispatcher_tb_top.sv
// Self-checking testbench of the interrupt dispatcher
`timescale 1ns/1ns
`default_nettype none
module pid_dispatcher_tb_top;
  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] bits;
    logic [7:0] exp;
  } pid_row_t;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic mask_wr = 1'b0, fast_cfg_wr = 1'b0, hsb_range = 1'b0, handler_done = 1'b0;
  logic [3:0] mask_data = 4'h0, pend_clr = 4'h0, refresh_en = 4'h1;
  logic [1:0] tmr_en = 2'h0, port_abs = 2'h0, hsb_in = 2'h0;
  logic [15:0] tmr0_period = 16'h0000, tmr1_period = 16'h0000, abs_code1 = 16'h0000, abs_code2 = 16'h0000;
  logic [15:0] cmp_lo = 16'h0003, cmp_hi = 16'h0008, hsb_lo = 16'h0001, hsb_hi = 16'h0002;
  logic [4:0] fast_cfg = 5'h00;
  logic [2:0] cmp_range = 3'h0;
  wire logic [3:0] ext_in, mask_status, handler_id;
  wire logic [2:0] ctr0_in;
  wire logic [1:0] port_a, port_b, run_level;
  wire logic serial_req, handler_start, handler_resume, refresh_req, hsb_pattern;
  wire logic [9:0] pend_status;
  wire logic [15:0] fast_irq_sel;
  logic [7:0] ev_q[$];
  int fail_count = 0;
  int check_count = 0;
  // Rows: kind 0 input edge, 1 serial message, 2 board counter steps; exp = resume, refresh, level, id
  pid_row_t rows [6] = '{'{2'h0, 4'h1, 8'h70}, '{2'h0, 4'h2, 8'h31}, '{2'h0, 4'h4, 8'h32},
                         '{2'h0, 4'h8, 8'h33}, '{2'h1, 4'h0, 8'h19}, '{2'h2, 4'h3, 8'h34}};

  always #2 sys_clk = ~sys_clk;

  pid_src_model src (.sys_clk(sys_clk), .ext_in(ext_in), .serial_req(serial_req), .ctr0_in(ctr0_in),
    .port_a(port_a), .port_b(port_b));

  pid_dispatcher #(.TICK_CYCLES(10)) uut (.sys_clk(sys_clk), .rst(rst), .ext_in(ext_in), .mask_wr(mask_wr),
    .mask_data(mask_data), .pend_clr(pend_clr), .refresh_en(refresh_en), .tmr_en(tmr_en),
    .tmr0_period(tmr0_period), .tmr1_period(tmr1_period), .fast_cfg_wr(fast_cfg_wr), .fast_cfg(fast_cfg),
    .ctr0_in(ctr0_in), .port_a(port_a), .port_b(port_b), .port_abs(port_abs), .abs_code1(abs_code1),
    .abs_code2(abs_code2), .cmp_range(cmp_range), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi), .hsb_in(hsb_in),
    .hsb_lo(hsb_lo), .hsb_hi(hsb_hi), .hsb_range(hsb_range), .serial_req(serial_req),
    .handler_done(handler_done), .handler_start(handler_start), .handler_id(handler_id),
    .handler_resume(handler_resume), .refresh_req(refresh_req), .run_level(run_level),
    .mask_status(mask_status), .pend_status(pend_status), .fast_irq_sel(fast_irq_sel),
    .hsb_pattern(hsb_pattern));

  // Starts and resumes are one-cycle pulses, so they are queued as they happen
  always @(posedge sys_clk)
  begin
    #1;
    if (handler_start === 1'b1 || handler_resume === 1'b1)
      ev_q.push_back({handler_resume, refresh_req, run_level, handler_id});
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic expect_ev(input logic [7:0] exp);
    int n;
    n = 0;
    while (ev_q.size() == 0 && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    #2;
    check({8'h00, (ev_q.size() > 0) ? ev_q.pop_front() : 8'h00}, {8'h00, exp});
  endtask

  task automatic done_pulse();
    @(posedge sys_clk);
    handler_done <= 1'b1;
    @(posedge sys_clk);
    handler_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    step(1);
    check(16'(mask_status), 16'h000f);
    check(fast_irq_sel, 16'hffff);
    check(16'(pend_status), 16'h0000);
    $display("test reset done");
    src.raise_inputs(4'hc);
    step(4);
    check(16'(pend_status[3:2]), 16'h0003);
    check(16'(ev_q.size()), 16'h0000);
    @(posedge sys_clk);
    pend_clr <= 4'h8;
    @(posedge sys_clk);
    pend_clr <= 4'h0;
    mask_wr <= 1'b1;
    @(posedge sys_clk);
    mask_wr <= 1'b0;
    expect_ev(8'h32);
    done_pulse();
    step(6);
    check(16'(pend_status) | 16'(ev_q.size()), 16'h0000);
    $display("test mask done");
    foreach (rows[i])
    begin
      case (rows[i].kind)
        2'h0: src.raise_inputs(rows[i].bits);
        2'h1: src.message_received();
        default: src.quad_steps(rows[i].bits);
      endcase
      expect_ev(rows[i].exp);
      done_pulse();
    end
    $display("test rows done");
    src.raise_inputs(4'hf);
    for (int i = 0; i < 4; i++)
    begin
      expect_ev({1'b0, i == 0, 2'h3, 4'(i)});
      if (i == 0)
        check(16'(pend_status[3:1]), 16'h0007);
      done_pulse();
    end
    $display("test tie done");
    src.message_received();
    expect_ev(8'h19);
    src.raise_inputs(4'h2);
    expect_ev(8'h31);
    done_pulse();
    expect_ev(8'h99);
    done_pulse();
    $display("test preempt done");
    @(posedge sys_clk);
    tmr0_period <= 16'h0002;
    tmr1_period <= 16'h0002;
    tmr_en <= 2'h3;
    expect_ev(8'h26);
    @(posedge sys_clk);
    tmr_en <= 2'h0;
    done_pulse();
    expect_ev(8'h27);
    done_pulse();
    $display("test timer done");
    @(posedge sys_clk);
    port_abs <= 2'h2;
    cmp_range <= 3'h4;
    abs_code2 <= 16'h0005;
    expect_ev(8'h35);
    @(posedge sys_clk);
    abs_code2 <= 16'h0000;
    done_pulse();
    expect_ev(8'h35);
    done_pulse();
    src.ctr0_steps(4'h3);
    expect_ev(8'h28);
    done_pulse();
    @(posedge sys_clk);
    hsb_in <= 2'h1;
    step(3);
    check(16'(hsb_pattern), 16'h0001);
    check(16'(pend_status) | 16'(ev_q.size()), 16'h0000);
    $display("test counter done");
    @(posedge sys_clk);
    fast_cfg_wr <= 1'b1;
    fast_cfg <= 5'h08;
    @(posedge sys_clk);
    fast_cfg <= 5'h00;
    #1;
    check(fast_irq_sel, 16'h00ff);
    @(posedge sys_clk);
    fast_cfg_wr <= 1'b0;
    rst <= 1'b1;
    #1;
    check(fast_irq_sel, 16'h0000);
    @(posedge sys_clk);
    rst <= 1'b0;
    step(1);
    check({mask_status, 3'h0, hsb_pattern, 8'h00} | 16'(run_level), 16'hf000);
    check(fast_irq_sel, 16'hffff);
    $display("test fast and reset done");
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // pid_dispatcher_tb_top
`default_nettype wire
